// ---- design/lcd_pkg.sv ----
// lcd_pkg: command codes, register defaults, field positions, timing
// assumes a 100 MHz mclk and one byte per host strobe
package lcd_pkg;
    // command codes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_SOFT_REINIT = 8'h01;
    localparam logic [7:0] CMD_READ_IDENTITY = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h09;
    localparam logic [7:0] CMD_MEM_ACCESS = 8'h36;
    localparam logic [7:0] CMD_SCROLL_START = 8'h37;
    localparam logic [7:0] CMD_IDLE_OFF = 8'h38;
    localparam logic [7:0] CMD_IDLE_ON = 8'h39;
    localparam logic [7:0] CMD_PIXEL_FORMAT = 8'h3A;
    localparam logic [7:0] CMD_WRITE_CONTINUE = 8'h3C;
    localparam logic [7:0] CMD_READ_CONTINUE = 8'h3E;
    localparam logic [7:0] CMD_TEAR_SCAN = 8'h45;
    localparam logic [7:0] CMD_IDENTITY_1 = 8'hDA;
    localparam logic [7:0] CMD_IDENTITY_2 = 8'hDB;
    localparam logic [7:0] CMD_IDENTITY_3 = 8'hDC;

    // reset values
    localparam logic [7:0] MAC_RESET = 8'h00;
    localparam logic [15:0] SCROLL_RESET = 16'h0000;
    localparam logic [7:0] PIXFMT_RESET = 8'h66;
    // identity value, arbitrary
    localparam logic [23:0] IDENTITY_DEFAULT = 24'h5AA53C;

    // field positions
    localparam int MAC_FIELD_LSB = 2;
    localparam int PIX_VIDEO_LSB = 4;
    localparam int PIX_HOST_LSB = 0;
    localparam logic [2:0] FMT_12BPP = 3'h3;
    localparam logic [2:0] FMT_16BPP = 3'h5;
    localparam logic [2:0] FMT_18BPP = 3'h6;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int REINIT_TIME_NS = 5000000;
    localparam int REINIT_CYCLES = (REINIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // host write strobe with its byte
    typedef struct packed {
        logic valid;
        logic is_param;
        logic [7:0] data;
    } lcd_host_type;

    // mode flags owned by neighbouring blocks
    typedef struct packed {
        logic booster;
        logic partial;
        logic sleep_out;
        logic normal;
        logic scroll;
        logic inversion;
        logic display_on;
        logic tear_on;
        logic tear_mode;
    } lcd_mode_type;

    typedef enum logic {st_run, st_reinit} lcd_state_type;
endpackage : lcd_pkg

// ---- design/lcd_cmd_decoder.sv ----
// lcd_cmd_decoder: host command and status decoder of the display controller
// assumes host strobes synchronous to mclk; frame memory and power live outside
// Operation
// - command 00h takes no parameter and changes nothing.
// - command 01h reloads access control, scroll start, pixel format and idle mode with defaults.
// - soft reinit never touches frame memory contents.
// - soft reinit blanks screen, loads defaults and pulses sleep_enter, all in one cycle.
// - command 04h returns three identity bytes, high byte first.
// - DAh, DBh, DCh return identity bytes one, two, three.
// - command 09h returns four status bytes; byte 2 defaults 61h.
// - status bits mirror access control bits 7, 6 and 5.
// - status refresh order bit mirrors access control bit 4.
// - command 36h takes one byte; bits 7..2 kept, reset 00h.
// - command 37h takes two bytes, high first, scroll start line.
// - 38h leaves idle; 39h enters idle and turns other modes off.
// - these commands are accepted in every display and sleep mode.
// - colour format codes 011, 101, 110 mean 12, 16, 18 bpp.
// - tear mode 0 pulses in vblank only; 1 in hblank too.
`timescale 1ns/1ns
module lcd_cmd_decoder
    import lcd_pkg::*;
#(
    parameter int REINIT_COUNT = lcd_pkg::REINIT_CYCLES,
    parameter logic [23:0] IDENTITY = lcd_pkg::IDENTITY_DEFAULT
) (
    input wire logic mclk, // core clock
    input wire logic arst_n, // async reset
    input wire lcd_pkg::lcd_host_type host, // command or parameter write
    input wire logic rd_req, // read strobe
    output logic [7:0] rdata, // read byte
    output logic rd_valid, // read byte valid
    input wire lcd_pkg::lcd_mode_type modes, // external mode flags
    input wire logic [9:0] scan_line, // current scan line
    input wire logic vblank, // vertical blanking
    input wire logic hblank, // horizontal blanking
    output logic tear_out, // tearing output
    output logic [7:0] memory_access_control, // access control
    output logic [15:0] scroll_start_line, // scroll start
    output logic [7:0] pixel_format_select, // pixel format
    output logic format_defined, // host format is defined
    output logic idle_mode, // idle mode on
    output logic other_modes_off, // pulse: idle entered
    output logic mem_wr_continue, // pulse: resume write
    output logic mem_rd_continue, // pulse: resume read
    output logic sleep_enter, // pulse: enter sleep-in
    output logic reinit_busy, // reinit in progress
    output logic screen_blank // whole screen blank
);
    import lcd_pkg::*;

    localparam int CW = $clog2(REINIT_COUNT + 1);

    lcd_state_type state;
    logic [CW-1:0] reinit_cnt;
    logic [7:0] cur_cmd;
    logic [1:0] par_idx;
    logic [1:0] rd_idx;
    logic [7:0] scroll_hi;
    logic [9:0] scan_snap;
    logic [7:0] next_rdata;
    logic [31:0] status_word;
    logic cmd_stb;
    logic par_stb;
    logic reinit_go;

    // writes during reinit are dropped
    assign cmd_stb = host.valid && !host.is_param && state == st_run;
    assign par_stb = host.valid && host.is_param && state == st_run;
    assign reinit_go = cmd_stb && host.data == CMD_SOFT_REINIT;
    assign reinit_busy = state == st_reinit;
    assign screen_blank = reinit_busy;

    // reinit window
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= st_run;
            reinit_cnt <= '0;
        end else begin
            case (state)
                st_run: begin
                    if (reinit_go) begin
                        state <= st_reinit;
                        reinit_cnt <= CW'(REINIT_COUNT - 1);
                    end
                end
                st_reinit: begin
                    if (reinit_cnt == '0) begin
                        state <= st_run;
                    end else begin
                        reinit_cnt <= reinit_cnt - 1'b1;
                    end
                end
                default: state <= st_run;
            endcase
        end
    end

    // current command and byte indices
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cur_cmd <= CMD_NOP;
            par_idx <= '0;
            rd_idx <= '0;
            scan_snap <= '0;
        end else begin
            if (cmd_stb) begin
                cur_cmd <= host.data;
                par_idx <= '0;
                rd_idx <= '0;
                if (host.data == CMD_TEAR_SCAN) begin
                    scan_snap <= scan_line;
                end
            end else begin
                if (par_stb && par_idx != 2'h3) begin
                    par_idx <= par_idx + 1'b1;
                end
                if (rd_req && rd_idx != 2'h3) begin
                    rd_idx <= rd_idx + 1'b1;
                end
            end
        end
    end

    // registers; frame memory is not here, reinit cannot reach it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            memory_access_control <= MAC_RESET;
            scroll_start_line <= SCROLL_RESET;
            pixel_format_select <= PIXFMT_RESET;
            scroll_hi <= '0;
        end else if (reinit_go) begin
            memory_access_control <= MAC_RESET;
            scroll_start_line <= SCROLL_RESET;
            pixel_format_select <= PIXFMT_RESET;
            scroll_hi <= '0;
        end else if (par_stb) begin
            case (cur_cmd)
                CMD_MEM_ACCESS: begin
                    if (par_idx == 2'h0) begin
                        memory_access_control <= {host.data[7:MAC_FIELD_LSB], 2'b00};
                    end
                end
                CMD_SCROLL_START: begin
                    if (par_idx == 2'h0) begin
                        scroll_hi <= host.data;
                    end else if (par_idx == 2'h1) begin
                        scroll_start_line <= {scroll_hi, host.data};
                    end
                end
                CMD_PIXEL_FORMAT: begin
                    if (par_idx == 2'h0) begin
                        pixel_format_select <= {1'b0, host.data[PIX_VIDEO_LSB+:3],
                            1'b0, host.data[PIX_HOST_LSB+:3]};
                    end
                end
                default: ;
            endcase
        end
    end

    // idle mode and one-cycle command pulses
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            idle_mode <= 1'b0;
            other_modes_off <= 1'b0;
            mem_wr_continue <= 1'b0;
            mem_rd_continue <= 1'b0;
            sleep_enter <= 1'b0;
        end else begin
            if (reinit_go || (cmd_stb && host.data == CMD_IDLE_OFF)) begin
                idle_mode <= 1'b0;
            end else if (cmd_stb && host.data == CMD_IDLE_ON) begin
                idle_mode <= 1'b1;
            end
            other_modes_off <= cmd_stb && host.data == CMD_IDLE_ON;
            mem_wr_continue <= cmd_stb && host.data == CMD_WRITE_CONTINUE;
            mem_rd_continue <= cmd_stb && host.data == CMD_READ_CONTINUE;
            sleep_enter <= reinit_go;
        end
    end

    // status bytes 1 to 4, high byte first
    assign status_word = {
        modes.booster, memory_access_control[7:MAC_FIELD_LSB], 1'b0,
        1'b0, pixel_format_select[PIX_HOST_LSB+:3], idle_mode,
        modes.partial, modes.sleep_out, modes.normal,
        modes.scroll, 1'b0, modes.inversion, 2'b00,
        modes.display_on, modes.tear_on, 1'b0,
        modes.tear_mode, 7'h00
    };

    function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] i);
        pick = w[8'(31 - 8 * i) -: 8];
    endfunction : pick

    // read byte selection; past the last byte zero, except status repeats byte 4
    always_comb begin
        next_rdata = 8'h00;
        case (cur_cmd)
            CMD_READ_IDENTITY: next_rdata = pick({IDENTITY, 8'h00}, rd_idx);
            CMD_READ_STATUS: next_rdata = pick(status_word, rd_idx);
            CMD_TEAR_SCAN: next_rdata = pick({6'h00, scan_snap, 16'h0000}, rd_idx);
            CMD_IDENTITY_1: next_rdata = rd_idx == 2'h0 ? IDENTITY[23:16] : 8'h00;
            CMD_IDENTITY_2: next_rdata = rd_idx == 2'h0 ? IDENTITY[15:8] : 8'h00;
            CMD_IDENTITY_3: next_rdata = rd_idx == 2'h0 ? IDENTITY[7:0] : 8'h00;
            default: next_rdata = 8'h00;
        endcase
    end

    // reads answered in every mode
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rdata <= next_rdata;
            end
        end
    end

    // tearing output and format check
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tear_out <= 1'b0;
            format_defined <= 1'b0;
        end else begin
            tear_out <= modes.tear_on && (vblank || (modes.tear_mode && hblank));
            format_defined <= pixel_format_select[2:0] == FMT_12BPP
                || pixel_format_select[2:0] == FMT_16BPP
                || pixel_format_select[2:0] == FMT_18BPP;
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!arst_n);

    nop_no_change_a: assert property (
        cmd_stb && host.data == CMD_NOP |=> $stable(memory_access_control)
        && $stable(pixel_format_select) && $stable(scroll_start_line) && $stable(idle_mode))
        else $error("nop changed state");

    reinit_defaults_a: assert property (
        reinit_go |=> memory_access_control == MAC_RESET
        && scroll_start_line == SCROLL_RESET && pixel_format_select == PIXFMT_RESET)
        else $error("reinit defaults wrong");

    reinit_sleep_a: assert property (
        reinit_go |=> screen_blank && sleep_enter && !idle_mode ##1 !sleep_enter)
        else $error("reinit sequence wrong");

    ident_order_a: assert property (
        cmd_stb && host.data == CMD_READ_IDENTITY ##1 rd_req |=> rdata == IDENTITY[23:16])
        else $error("identity first byte wrong");

    ident_single_a: assert property (
        rd_req && cur_cmd == CMD_IDENTITY_2 && rd_idx == 2'h0 |=> rdata == IDENTITY[15:8])
        else $error("identity byte two wrong");

    status_two_a: assert property (
        rd_req && cur_cmd == CMD_READ_STATUS && rd_idx == 2'h1
        |=> rd_valid && rdata[6:4] == $past(pixel_format_select[2:0])
        && rdata[3] == $past(idle_mode) && rdata[7] == 1'b0)
        else $error("status byte two wrong");

    status_mirror_a: assert property (
        rd_req && cur_cmd == CMD_READ_STATUS && rd_idx == 2'h0
        |=> rdata[6:1] == $past(memory_access_control[7:2]) && rdata[0] == 1'b0)
        else $error("status access bits wrong");

    mac_write_a: assert property (
        par_stb && cur_cmd == CMD_MEM_ACCESS && par_idx == 2'h0
        |=> memory_access_control == {$past(host.data[7:2]), 2'b00})
        else $error("access control write wrong");

    sequence scroll_hi_s;
        par_stb && cur_cmd == CMD_SCROLL_START && par_idx == 2'h0;
    endsequence
    sequence scroll_lo_s;
        par_stb && cur_cmd == CMD_SCROLL_START && par_idx == 2'h1 && !reinit_go;
    endsequence
    scroll_pair_a: assert property (
        scroll_hi_s ##1 scroll_lo_s |=> scroll_start_line[7:0] == $past(host.data)
        && scroll_start_line[15:8] == $past(host.data, 2))
        else $error("scroll start pair wrong");

    idle_on_a: assert property (
        cmd_stb && host.data == CMD_IDLE_ON |=> idle_mode && other_modes_off)
        else $error("idle on wrong");

    continue_pulse_a: assert property (
        cmd_stb && host.data == CMD_WRITE_CONTINUE
        ##1 !(cmd_stb && host.data == CMD_WRITE_CONTINUE)
        |-> mem_wr_continue ##1 !mem_wr_continue)
        else $error("write continue pulse wrong");

    read_any_mode_a: assert property (
        rd_req |=> rd_valid)
        else $error("read not answered");

    tear_vblank_a: assert property (
        modes.tear_on && !modes.tear_mode && hblank && !vblank |=> !tear_out)
        else $error("tear pulse outside vblank");
endmodule : lcd_cmd_decoder

// ---- dv/lcd_host_model.sv ----
// lcd_host_model: host driving command, parameter and read strobes
// assumes the bench calls its tasks at falling mclk edges
`timescale 1ns/1ns
module lcd_host_model (
    input wire logic mclk, // core clock
    input wire logic reinit_busy, // device reinit window
    input wire logic rd_valid, // read byte valid
    input wire logic [7:0] rdata, // read byte
    output lcd_pkg::lcd_host_type host, // write strobe
    output logic rd_req, // read strobe
    output logic stuck // busy wait ran out
);
    import lcd_pkg::*;
    bit obey = 1'b1;
    initial begin
        host = '0;
        rd_req = 1'b0;
        stuck = 1'b0;
    end
    // one byte per call; strobe held for back-to-back bytes
    task automatic put(input logic is_param, input logic [7:0] data);
        int n;
        n = 0;
        rd_req = 1'b0;
        while (obey && reinit_busy !== 1'b0 && n < 100) begin
            host.valid = 1'b0;
            @(negedge mclk);
            n++;
        end
        if (obey && reinit_busy !== 1'b0) stuck = 1'b1;
        host = '{1'b1, is_param, data};
        @(negedge mclk);
    endtask : put
    task automatic get(output logic [7:0] data);
        host.valid = 1'b0;
        rd_req = 1'b1;
        @(negedge mclk);
        data = (rd_valid === 1'b1) ? rdata : 8'hXX;
    endtask : get
    // released data lines flip so stale bytes never look valid
    task automatic idle();
        host = '{1'b0, 1'b0, ~host.data};
        rd_req = 1'b0;
        @(negedge mclk);
    endtask : idle
endmodule : lcd_host_model

// ---- dv/test_lcd_cmd_decoder.sv ----
// test_lcd_cmd_decoder: self-checking bench of the command decoder
// assumes lcd_host_model on the host side; inputs move at falling edges
`timescale 1ns/1ns
module test_lcd_cmd_decoder;
    import lcd_pkg::*;
    localparam int REINIT_TB = 8;
    localparam logic [23:0] ID_TB = 24'h3C5AA5; // arbitrary identity
    logic mclk, arst_n, rd_req, rd_valid, vblank, hblank, tear_out, stuck;
    logic fmt_ok, idle_mode, modes_off, wr_cont, rd_cont, sleep_enter, busy, blank;
    logic [7:0] rdata, mac, pix;
    logic [15:0] scroll;
    logic [9:0] scan_line;
    lcd_host_type host;
    lcd_mode_type modes;
    int miscompares = 0;
    int check_count = 0;
    lcd_cmd_decoder #(.REINIT_COUNT(REINIT_TB), .IDENTITY(ID_TB)) i_dut (
        .mclk(mclk), .arst_n(arst_n), .host(host), .rd_req(rd_req), .rdata(rdata),
        .rd_valid(rd_valid), .modes(modes), .scan_line(scan_line), .vblank(vblank),
        .hblank(hblank), .tear_out(tear_out), .memory_access_control(mac),
        .scroll_start_line(scroll), .pixel_format_select(pix), .format_defined(fmt_ok),
        .idle_mode(idle_mode), .other_modes_off(modes_off), .mem_wr_continue(wr_cont),
        .mem_rd_continue(rd_cont), .sleep_enter(sleep_enter), .reinit_busy(busy),
        .screen_blank(blank));
    lcd_host_model i_host (.mclk(mclk), .reinit_busy(busy), .rd_valid(rd_valid),
        .rdata(rdata), .host(host), .rd_req(rd_req), .stuck(stuck));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] expt);
        check_count++;
        if (seen !== expt) begin
            miscompares++;
            $display("ERROR t=%0t seen=%0h expected=%0h", $time, seen, expt);
        end
    endtask : check
    task automatic rd(input logic [7:0] expt);
        logic [7:0] b;
        i_host.get(b);
        check(b, expt);
    endtask : rd
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    always @(posedge stuck) begin
        miscompares++;
        complete_run();
    end
    task automatic t_reset();
        check({mac, scroll}, {MAC_RESET, SCROLL_RESET});
        check({pix, fmt_ok, idle_mode}, {PIXFMT_RESET, 2'b10});
    endtask : t_reset
    task automatic t_status();
        logic [31:0] e;
        i_host.put(1'b0, CMD_MEM_ACCESS);
        i_host.put(1'b1, 8'hA7);
        i_host.put(1'b1, 8'h11);
        i_host.idle();
        check(mac, 8'hA4);
        for (int k = 0; k < 2; k++) begin
            modes = k ? 9'h0A4 : 9'h15B;
            e = k ? 32'h52650400 : 32'hD262A280;
            i_host.put(1'b0, CMD_READ_STATUS);
            for (int j = 0; j < 4; j++) rd(e[31 - 8 * j -: 8]);
            rd(e[7:0]);
        end
    endtask : t_status
    task automatic t_scroll();
        i_host.put(1'b0, CMD_SCROLL_START);
        i_host.put(1'b1, 8'h01);
        i_host.put(1'b1, 8'h40);
        i_host.put(1'b0, CMD_SCROLL_START);
        i_host.put(1'b1, 8'h12);
        i_host.put(1'b0, CMD_NOP);
        i_host.put(1'b1, 8'h55);
        i_host.idle();
        check(scroll, 16'h0140);
        check({mac, pix, idle_mode}, {8'hA4, PIXFMT_RESET, 1'b0});
    endtask : t_scroll
    task automatic t_pixfmt();
        for (int c = 0; c < 8; c++) begin
            i_host.put(1'b0, CMD_PIXEL_FORMAT);
            i_host.put(1'b1, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
            i_host.idle();
            check(pix, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
            check(fmt_ok, (c == 3 || c == 5 || c == 6));
        end
    endtask : t_pixfmt
    task automatic t_idle();
        i_host.put(1'b0, CMD_IDLE_ON);
        check({idle_mode, modes_off}, 2'b11);
        i_host.put(1'b0, CMD_WRITE_CONTINUE);
        check({modes_off, wr_cont}, 2'b01);
        i_host.put(1'b0, CMD_READ_CONTINUE);
        check({wr_cont, rd_cont}, 2'b01);
        i_host.put(1'b0, CMD_READ_STATUS);
        rd(8'h52);
        rd(8'h7D);
        i_host.put(1'b0, CMD_IDLE_OFF);
        i_host.idle();
        check({idle_mode, rd_cont}, 2'b00);
    endtask : t_idle
    task automatic t_ident();
        i_host.put(1'b0, CMD_READ_IDENTITY);
        for (int j = 0; j < 3; j++) rd(ID_TB[23 - 8 * j -: 8]);
        rd(8'h00);
        for (int k = 0; k < 3; k++) begin
            i_host.put(1'b0, 8'(CMD_IDENTITY_1 + k));
            rd(ID_TB[23 - 8 * k -: 8]);
        end
        scan_line = 10'h2B7;
        i_host.put(1'b0, CMD_TEAR_SCAN);
        rd(8'h02);
        rd(8'hB7);
    endtask : t_ident
    task automatic t_tear();
        for (int v = 0; v < 16; v++) begin
            modes.tear_on = v[3];
            modes.tear_mode = v[2];
            vblank = v[1];
            hblank = v[0];
            @(negedge mclk);
            check(tear_out, v[3] & (v[1] | v[2] & v[0]));
        end
    endtask : t_tear
    task automatic t_reinit();
        int n;
        i_host.put(1'b0, CMD_IDLE_ON);
        i_host.put(1'b0, CMD_SOFT_REINIT);
        check({sleep_enter, busy, blank, idle_mode}, 4'hE);
        check({mac, scroll, pix}, {MAC_RESET, SCROLL_RESET, PIXFMT_RESET});
        i_host.obey = 1'b0;
        i_host.put(1'b0, CMD_MEM_ACCESS);
        check(sleep_enter, 1'b0);
        i_host.put(1'b1, 8'hFC);
        i_host.obey = 1'b1;
        i_host.idle();
        rd(8'h00);
        n = 5;
        while (busy === 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        check(n, REINIT_TB + 1);
        check({mac, blank}, {MAC_RESET, 1'b0});
        i_host.put(1'b0, CMD_MEM_ACCESS);
        i_host.put(1'b1, 8'h08);
        i_host.idle();
        check(mac, 8'h08);
    endtask : t_reinit
    initial begin
        arst_n = 1'b0;
        modes = '0;
        scan_line = '0;
        vblank = 1'b0;
        hblank = 1'b0;
        repeat (4) @(negedge mclk);
        arst_n = 1'b1;
        @(negedge mclk);
        t_reset();
        t_status();
        t_scroll();
        t_pixfmt();
        t_idle();
        t_ident();
        t_tear();
        t_reinit();
        complete_run();
    end
endmodule : test_lcd_cmd_decoder
